// >>> rtl/serial_in_latched_parallel_out.sv
`timescale 1ns/1ps
`include "sipo_defs.svh"
// Functional notes
// - eight shift stages and eight storage bits; storage drives the parallel outputs
// - shift_clk rising edge: serial_in into stage 0, others move one stage up
// - store_clk rising edge: copy shift stages into storage, which drives par_out
// - shift_clear_n low clears all shift stages at once
// - store_clear_n low clears storage and par_out at once
// - both paths clocked and cleared independently, clears act without a clock
// - with tied clocks, storage takes the pre-edge shift contents
// - last shift stage appears on cascade_out for chaining
module serial_in_latched_parallel_out
	import sipo_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  resetn,
	input  wire logic  shift_clk,
	input  wire logic  store_clk,
	input  wire logic  shift_clear_n,
	input  wire logic  store_clear_n,
	input  wire logic  serial_in,
	output word_t      par_out,
	output logic       cascade_out,
	output logic       word_valid,
	output word_t      word_data,
	input  wire logic  word_ready
);
	word_t     shift_q;
	word_t     next_shift_q;
	word_t     store_q;
	word_t     next_store_q;
	word_t     snap;
	word_t     next_snap;
	logic      req;
	logic      next_req;
	logic      ack_s1;
	logic      ack_s2;
	logic      req_s1;
	logic      req_s2;
	logic      ack;
	logic      next_ack;
	word_t     mem [`FIFO_DEPTH];
	logic      wr_ptr;
	logic      next_wr_ptr;
	logic      rd_ptr;
	logic      next_rd_ptr;
	fifo_cnt_t cnt;
	fifo_cnt_t next_cnt;
	logic      push;
	logic      pop;
	logic      fifo_ready;

	// shift path on its own clock and clear
	always_comb
	begin
		next_shift_q = {shift_q[`STAGE_MSB-1:0], serial_in};
	end

	always_ff @(posedge shift_clk or negedge shift_clear_n)
	begin
		if (!shift_clear_n)
			shift_q <= `WORD_ZERO;
		else
			shift_q <= next_shift_q;
	end

	assign cascade_out = shift_q[`STAGE_MSB];

	// storage path; a plain flop samples shift_q before it changes on a shared edge
	always_comb
	begin
		next_store_q = shift_q;
	end

	always_ff @(posedge store_clk or negedge store_clear_n)
	begin
		if (!store_clear_n)
			store_q <= `WORD_ZERO;
		else
			store_q <= next_store_q;
	end

	assign par_out = store_q;

	// snapshot for the system side; a store during a pending handshake is not
	// forwarded, the parallel outputs still update
	// limitation: the returning acknowledge needs two store_clk edges to be seen,
	// so after the store clock has stopped the next word leaves on its third edge
	always_comb
	begin
		next_snap = snap;
		next_req  = req;
		if (req == ack_s2)
		begin
			next_snap = shift_q;
			next_req  = ~req;
		end
	end

	always_ff @(posedge store_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			snap <= `WORD_ZERO;
			req  <= 1'b0;
		end
		else
		begin
			snap <= next_snap;
			req  <= next_req;
		end
	end

	// acknowledge back into the store domain; only the second stage is read
	always_ff @(posedge store_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end
		else
		begin
			ack_s1 <= ack;
			ack_s2 <= ack_s1;
		end
	end

	// request into the system domain; snap stays still while req_s2 differs
	// from ack, so the word itself needs no synchroniser
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
		end
		else
		begin
			req_s1 <= req;
			req_s2 <= req_s1;
		end
	end

	// system side: accept a word only when the buffer has room, so a stalled
	// consumer holds the handshake and never loses a buffered word
	assign fifo_ready = (cnt != `FIFO_CNT_FULL);
	assign push       = (req_s2 != ack) && fifo_ready;
	assign pop        = word_valid && word_ready;
	assign word_valid = (cnt != `FIFO_CNT_ZERO);
	assign word_data  = mem[rd_ptr];

	always_comb
	begin
		next_ack    = ack;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_cnt    = cnt;
		if (push)
		begin
			next_wr_ptr = ~wr_ptr;
			next_ack    = ~ack;
		end
		if (pop)
			next_rd_ptr = ~rd_ptr;
		if (push && !pop)
			next_cnt = cnt + `FIFO_CNT_ONE;
		else if (pop && !push)
			next_cnt = cnt - `FIFO_CNT_ONE;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ack    <= 1'b0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			cnt    <= `FIFO_CNT_ZERO;
		end
		else
		begin
			ack    <= next_ack;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt    <= next_cnt;
		end
	end

	// one register per buffer entry; only the addressed entry loads on a push,
	// the other keeps a word the consumer has not taken yet
	genvar e;
	generate
		for (e = 0; e < `FIFO_DEPTH; e++)
		begin : g_entry
			word_t next_entry;
			always_comb
			begin
				next_entry = mem[e];
				if (push && (wr_ptr == 1'(e)))
					next_entry = snap;
			end

			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
					mem[e] <= `WORD_ZERO;
				else
					mem[e] <= next_entry;
			end
		end
	endgenerate
endmodule

// >>> rtl/sipo_defs.svh
`ifndef SIPO_DEFS_SVH
`define SIPO_DEFS_SVH
`define STAGE_COUNT   8
`define STAGE_MSB     7
`define WORD_ZERO     8'h00
`define FIFO_DEPTH    2
`define FIFO_CNT_ZERO 2'h0
`define FIFO_CNT_ONE  2'h1
`define FIFO_CNT_FULL 2'h2
`endif

// >>> rtl/sipo_pkg.sv
package sipo_pkg;
	typedef logic [7:0] word_t;
	typedef logic [1:0] fifo_cnt_t;
endpackage

// >>> verification/serial_in_latched_parallel_out_test.sv
`timescale 1ns/1ps
module serial_in_latched_parallel_out_test;
	import sipo_pkg::*;
	logic  sys_clk = 0, resetn = 0, word_ready = 0, fill = 1, shift_clear_n = 0;
	logic  store_clear_n = 0, shift_clk, serial_in, cascade_out, word_valid;
	word_t par_out, word_data, b, sh = 8'h00, q[$];
	int    n_fail = 0, samples_checked = 0, cyc = 0, sent = 0;
	always #50 sys_clk = ~sys_clk;
	sipo_ctrl ctl (.*);
	serial_in_latched_parallel_out dut (.*, .store_clk(shift_clk));
	task check(input string s, input word_t seen, input word_t exp);
		samples_checked++;
		if (seen !== exp)
			$display("Error %s exp %h seen %h", s, exp, seen);
		n_fail += (seen !== exp);
	endtask
	task final_report(input int t);
		n_fail += t;
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// after reset the first tied edge forwards what is left; later frames need two
	// edges to see the acknowledge, so the third edge forwards two new bits on top
	task send;
		b = 8'($urandom);
		q.push_back((sent == 0) ? sh : {sh[5:0], b[7:6]});
		sent++;
		sh = {b[6:0], ~b[0]};
		ctl.frame(b);
		repeat (20) @(posedge sys_clk);
		#1 check("par_out", par_out, b);
	endtask
	always @(posedge sys_clk)
		word_ready <= #1 !fill & 1'($urandom);
	always @(posedge sys_clk)
		if (++cyc == 500)
			final_report(1);
	always @(negedge sys_clk)
		if (word_valid === 1'b1 && word_ready)
			check("word_data", word_data, q.pop_front());
	initial
	begin
		void'($urandom(23));
		repeat (2) @(posedge sys_clk);
		#1 {resetn, shift_clear_n, store_clear_n} = 3'h7;
		repeat (2) send;
		fill = 0;
		repeat (5) send;
		store_clear_n = 0;
		#200 store_clear_n = 1;
		send;
		{shift_clear_n, sh} = 9'h000;
		#200 shift_clear_n = 1;
		send;
		#2000 check("queue", 8'(q.size()), 8'h00);
		final_report(0);
	end
endmodule

// >>> verification/sipo_ctrl.sv
`timescale 1ns/1ps
module sipo_ctrl
	import sipo_pkg::*;
(
	output logic shift_clk = 1'h0,
	output logic serial_in = 1'h0
);
	// clocks are tied, so a ninth pulse loads storage; the line flips just before it, so that pulse shifts in ~b[0]
	task frame(input word_t b);
		for (int i = 8; i >= 0; i--)
		begin
			serial_in = (i > 0) ? b[i - 1] : ~serial_in;
			#3 shift_clk = 1'h1;
			#3 shift_clk = 1'h0;
		end
	endtask
endmodule

// >>> verification/sipo_sva.sv
`timescale 1ns/1ps
module sipo_sva
	import sipo_pkg::*;
(
	input logic  sys_clk,
	input logic  resetn,
	input logic  shift_clk,
	input logic  shift_clear_n,
	input logic  store_clear_n,
	input logic  serial_in,
	input word_t par_out,
	input logic  cascade_out,
	input logic  word_valid,
	input logic  word_ready,
	input word_t word_data
);
	logic [1:0] n;
	// history from before a clear is stale, so wait two clean edges
	always_ff @(posedge shift_clk or negedge shift_clear_n or negedge store_clear_n)
		if (!shift_clear_n || !store_clear_n)
			n <= 2'h0;
		else if (!n[1])
			n <= n + 2'h1;
	a_msb_follow: assert property (@(posedge shift_clk) disable iff (!resetn)
		n[1] |-> par_out[7] == $past(cascade_out)) else $error("msb lag");
	a_shift_up: assert property (@(posedge shift_clk) disable iff (!resetn)
		n[1] |-> par_out[7:1] == $past(par_out[6:0])) else $error("shift order");
	a_lsb_in: assert property (@(posedge shift_clk) disable iff (!resetn)
		n[1] |-> par_out[0] == $past(serial_in, 2)) else $error("serial capture");
	a_shift_clr: assert property (@(posedge sys_clk)
		!shift_clear_n |-> !cascade_out) else $error("shift clear");
	a_store_clr: assert property (@(posedge sys_clk)
		!store_clear_n |-> par_out == 8'h00) else $error("store clear");
	a_clr_indep: assert property (@(posedge sys_clk) disable iff (!resetn)
		store_clear_n && !shift_clear_n && !$past(shift_clear_n) |-> $stable(par_out))
		else $error("clear crosstalk");
	a_word_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		word_valid && !word_ready |=> word_valid && $stable(word_data)) else $error("word dropped");
	a_word_idle: assert property (@(posedge sys_clk)
		!resetn |-> !word_valid) else $error("idle");
	c_pop: cover property (@(posedge sys_clk) word_valid && word_ready);
	c_store_clr: cover property (@(posedge sys_clk) !store_clear_n);
	c_deep: cover property (@(posedge shift_clk) n[1]);
endmodule
bind serial_in_latched_parallel_out sipo_sva chk (.*);
